//--- design/espio_top.sv
`timescale 1ns/1ps
// Functional notes
// - Forty-eight lines appear as six consecutive eight-bit group registers.
// - Six-bit lock mask; a set bit blocks host writes to that group.
// - Each line works as input, output, or output with readback.
// - Reading a group returns the present pin state of its lines.
// - Written output values stay latched until the host writes again.
// - Edge detection exists only on the first three groups.
// - Each event line has a polarity bit and an enable bit.
// - A selected edge on an enabled line sets a sticky event latch.
// - Identification registers show which event lines hold latched events.
// - Interrupt request is high while any enabled line holds an event.
// - Block decodes a 32-byte window at a base that is a multiple of 64.
module espio_top
  import espio_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BASE_ADDR = 10'h300
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire espio_req_t           host_req,
  output logic [GROUP_W-1:0]        host_rdata,
  output logic                      host_rvalid,
  input  wire logic [NUM_LINES-1:0] line_in,
  output logic [NUM_LINES-1:0]      line_out,
  output logic [NUM_LINES-1:0]      line_oe_n,
  output logic                      irq
);

  logic [NUM_LINES-1:0] out_latch;
  logic [NUM_GROUPS-1:0] lock_mask;
  logic [EVT_LINES-1:0] polarity;
  logic [EVT_LINES-1:0] enable;
  logic [EVT_LINES-1:0] event_flag;
  logic [EVT_LINES-1:0] line_prev;
  logic [EVT_LINES-1:0] edge_hit;
  logic [EVT_LINES-1:0] clr_vec;
  logic                 sel;
  logic [WIN_W-1:0]     ofs;

  function automatic logic in_range(input logic [WIN_W-1:0] a, input logic [WIN_W-1:0] lo,
                                    input int n);
    return (a >= lo) && (a < lo + WIN_W'(n));
  endfunction

  // Base sits on a 64 boundary; only the low 32 bytes answer.
  assign sel = (host_req.addr[ADDR_W-1:WIN_W+1] == BASE_ADDR[ADDR_W-1:WIN_W+1]) &&
               (host_req.addr[WIN_W] == 1'b0);
  assign ofs = host_req.addr[WIN_W-1:0];

  // Open-collector: a latched one pulls low, a zero releases to the pull-up.
  // The driver enables are the latch itself, so the pins come straight from flip-flops.
  assign line_out  = {NUM_LINES{1'b0}};
  assign out_latch = ~line_oe_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_oe_n <= {NUM_GROUPS{~RESET_BYTE}};
      lock_mask <= RESET_LOCK;
      polarity  <= {EVT_LINES{1'b0}};
      enable    <= {EVT_LINES{1'b0}};
    end else if (host_req.wr && sel) begin
      if (in_range(ofs, OFS_GROUP0, NUM_GROUPS)) begin
        if (!lock_mask[3'(ofs - OFS_GROUP0)]) begin
          line_oe_n[GROUP_W*(ofs - OFS_GROUP0) +: GROUP_W] <= ~host_req.wdata;
        end
      end else if (ofs == OFS_LOCK) begin
        lock_mask <= host_req.wdata[NUM_GROUPS-1:0];
      end else if (in_range(ofs, OFS_POL0, EVT_GROUPS)) begin
        polarity[GROUP_W*(ofs - OFS_POL0) +: GROUP_W] <= host_req.wdata;
      end else if (in_range(ofs, OFS_EN0, EVT_GROUPS)) begin
        enable[GROUP_W*(ofs - OFS_EN0) +: GROUP_W] <= host_req.wdata;
      end
    end
  end

  // Clear register: writing a one clears that line's event.
  always_comb begin
    clr_vec = {EVT_LINES{1'b0}};
    if (host_req.wr && sel && in_range(ofs, OFS_CLR0, EVT_GROUPS)) begin
      clr_vec[GROUP_W*(ofs - OFS_CLR0) +: GROUP_W] = host_req.wdata;
    end
  end

  // Polarity one selects rising, zero falling; only groups 0..2 are sensed.
  assign edge_hit = enable & ((polarity & line_in[EVT_LINES-1:0] & ~line_prev) |
                              (~polarity & ~line_in[EVT_LINES-1:0] & line_prev));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_prev <= {EVT_LINES{1'b0}};
    end else begin
      line_prev <= line_in[EVT_LINES-1:0];
    end
  end

  // A new edge wins over a clear in the same cycle, so no event is lost.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      event_flag <= {EVT_LINES{1'b0}};
    end else begin
      event_flag <= (event_flag & ~clr_vec) | edge_hit;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((event_flag & ~clr_vec) | edge_hit) & enable);
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_rdata  <= RESET_BYTE;
      host_rvalid <= 1'b0;
    end else begin
      host_rvalid <= host_req.rd && sel;
      if (!(host_req.rd && sel)) begin
        host_rdata <= RESET_BYTE;
      end else if (in_range(ofs, OFS_GROUP0, NUM_GROUPS)) begin
        host_rdata <= line_in[GROUP_W*(ofs - OFS_GROUP0) +: GROUP_W];
      end else if (ofs == OFS_LOCK) begin
        host_rdata <= GROUP_W'(lock_mask);
      end else if (in_range(ofs, OFS_POL0, EVT_GROUPS)) begin
        host_rdata <= polarity[GROUP_W*(ofs - OFS_POL0) +: GROUP_W];
      end else if (in_range(ofs, OFS_EN0, EVT_GROUPS)) begin
        host_rdata <= enable[GROUP_W*(ofs - OFS_EN0) +: GROUP_W];
      end else if (in_range(ofs, OFS_EVT0, EVT_GROUPS)) begin
        host_rdata <= event_flag[GROUP_W*(ofs - OFS_EVT0) +: GROUP_W];
      end else begin
        host_rdata <= RESET_BYTE;
      end
    end
  end

  property p_lock_blocks;
    @(posedge core_clk) disable iff (!reset_n)
      (host_req.wr && sel && ofs < OFS_LOCK && lock_mask[3'(ofs)])
        |=> $stable(out_latch);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("locked group written");

  property p_latch_holds;
    @(posedge core_clk) disable iff (!reset_n)
      !host_req.wr |=> $stable(out_latch);
  endproperty
  a_latch_holds: assert property (p_latch_holds) else $error("output latch changed");

  property p_event_sticky;
    @(posedge core_clk) disable iff (!reset_n)
      (event_flag[0] && !clr_vec[0]) |=> event_flag[0];
  endproperty
  a_event_sticky: assert property (p_event_sticky) else $error("event lost");

  property p_edge_latched;
    @(posedge core_clk) disable iff (!reset_n)
      edge_hit[0] |=> event_flag[0] ##0 irq;
  endproperty
  a_edge_latched: assert property (p_edge_latched) else $error("edge missed");

  property p_irq_cause;
    @(posedge core_clk) disable iff (!reset_n)
      irq |-> (|event_flag);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without event");

  property p_oe_follows;
    @(posedge core_clk) disable iff (!reset_n)
      (host_req.wr && sel && ofs == OFS_GROUP0 + 5'h01 && !lock_mask[1])
        |=> line_oe_n[2*GROUP_W-1:GROUP_W] == ~$past(host_req.wdata);
  endproperty
  a_oe_follows: assert property (p_oe_follows) else $error("driver mismatch");

  property p_read_pins;
    @(posedge core_clk) disable iff (!reset_n)
      (host_req.rd && sel && ofs == OFS_GROUP0)
        |=> host_rdata == $past(line_in[GROUP_W-1:0]);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("readback wrong");

  property p_no_evt_high;
    @(posedge core_clk) disable iff (!reset_n)
      (host_req.rd && sel && ofs == OFS_EVT0 + 5'(EVT_GROUPS))
        |=> host_rdata == RESET_BYTE;
  endproperty
  a_no_evt_high: assert property (p_no_evt_high) else $error("phantom event group");

  // A clear with no fresh edge must really drop the event.
  property p_clear_drops;
    @(posedge core_clk) disable iff (!reset_n)
      (clr_vec[0] && !edge_hit[0])
        |=> !event_flag[0];
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("event not cleared");

  // A disabled line must never latch, whatever its pin does.
  property p_disabled_quiet;
    @(posedge core_clk) disable iff (!reset_n)
      (!enable[2] && !event_flag[2])
        |=> !event_flag[2];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled line latched");

  property p_out_window;
    @(posedge core_clk) disable iff (!reset_n)
      (host_req.rd && !sel)
        |=> !host_rvalid;
  endproperty
  a_out_window: assert property (p_out_window) else $error("answer outside window");

  property p_irq_from_latch;
    @(posedge core_clk) disable iff (!reset_n)
      (|(event_flag & enable & ~clr_vec))
        |=> irq;
  endproperty
  a_irq_from_latch: assert property (p_irq_from_latch) else $error("pending event no irq");

  property p_lock_read;
    @(posedge core_clk) disable iff (!reset_n)
      (host_req.rd && sel && ofs == OFS_LOCK)
        |=> host_rdata == GROUP_W'($past(lock_mask));
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock mask readback wrong");

endmodule

//--- include/espio_pkg.sv
package espio_pkg;

  localparam int NUM_GROUPS    = 6;
  localparam int EVT_GROUPS    = 3;
  localparam int GROUP_W       = 8;
  localparam int NUM_LINES     = NUM_GROUPS * GROUP_W;
  localparam int EVT_LINES     = EVT_GROUPS * GROUP_W;
  localparam int ADDR_W        = 10;
  localparam int WIN_W         = 5;

  // Register indices inside the 32-byte window.
  localparam logic [4:0] OFS_GROUP0    = 5'h00;
  localparam logic [4:0] OFS_LOCK      = 5'h06;
  localparam logic [4:0] OFS_POL0      = 5'h08;
  localparam logic [4:0] OFS_EN0       = 5'h0b;
  localparam logic [4:0] OFS_EVT0      = 5'h0e;
  localparam logic [4:0] OFS_CLR0      = 5'h11;

  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [5:0] RESET_LOCK    = 6'h00;

  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic [ADDR_W-1:0]     addr;
    logic [GROUP_W-1:0]    wdata;
  } espio_req_t;

endpackage

//--- bench/espio_host.sv
`timescale 1ns/1ps
module espio_host
  import espio_pkg::*;
(
  input  wire logic               core_clk,
  output espio_req_t              host_req,
  input  wire logic [GROUP_W-1:0] host_rdata,
  input  wire logic               host_rvalid
);
  initial host_req = '0;
  // An idle cycle follows each access so strobes never change twice in one step.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [GROUP_W-1:0] d);
    host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk) #1;
    host_req = '0;
    @(posedge core_clk) #1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [GROUP_W-1:0] d,
                    output logic v);
    host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge core_clk) #1;
    d = host_rdata;
    v = host_rvalid;
    host_req = '0;
    @(posedge core_clk) #1;
  endtask
endmodule

//--- bench/tb_espio_top.sv
`timescale 1ns/1ps
module tb_espio_top
  import espio_pkg::*;
;
  localparam logic [ADDR_W-1:0] B = 10'h300;
  logic                 core_clk = 1'b0;
  logic                 reset_n  = 1'b0;
  espio_req_t           host_req;
  logic [GROUP_W-1:0]   host_rdata;
  logic                 host_rvalid;
  logic                 irq;
  logic [NUM_LINES-1:0] ext = '1;
  logic [NUM_LINES-1:0] line_in;
  logic [NUM_LINES-1:0] line_oe_n;
  logic [NUM_LINES-1:0] line_out;
  logic [GROUP_W-1:0]   d;
  logic                 v;
  int                   n_fail  = 0;
  int                   n_tests = 0;
  always #2.5 core_clk = ~core_clk;
  // Open collector with pull-up: a pin is low if either side pulls it low.
  assign line_in = ext & line_oe_n;
  espio_host host_u (.core_clk(core_clk), .host_req(host_req), .host_rdata(host_rdata),
                     .host_rvalid(host_rvalid));
  espio_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .host_req(host_req),
                   .host_rdata(host_rdata), .host_rvalid(host_rvalid), .line_in(line_in),
                   .line_out(line_out), .line_oe_n(line_oe_n), .irq(irq));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [4:0] o, input logic [7:0] e);
    host_u.rd(B + 10'(o), d, v);
    chk("rvalid", 8'h01, {7'h00, v});
    chk("rdata", e, d);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    #1 reset_n = 1'b1;
    for (int g = 0; g < 6; g++) ext[8*g+:8] = 8'(8'h12 * (g + 1));
    for (int g = 0; g < 6; g++) rdc(5'(g), 8'(8'h12 * (g + 1)));
    $display("test readback done");
    ext = '1;
    host_u.wr(B + 10'h001, 8'h0f);
    chk("oe_n", 8'hf0, line_oe_n[15:8]);
    chk("line_out", 8'h00, {7'h00, |line_out});
    rdc(5'h01, 8'hf0);
    host_u.wr(B + 10'h006, 8'h02);
    rdc(5'h06, 8'h02);
    host_u.wr(B + 10'h001, 8'hff);
    chk("locked", 8'hf0, line_oe_n[15:8]);
    host_u.wr(B + 10'h006, 8'h00);
    host_u.wr(B + 10'h001, 8'h00);
    chk("released", 8'hff, line_oe_n[15:8]);
    $display("test latch and lock done");
    ext[7:0] = 8'h02;
    host_u.wr(B + 10'h008, 8'h01);
    host_u.wr(B + 10'h00b, 8'h03);
    rdc(5'h08, 8'h01);
    rdc(5'h0b, 8'h03);
    chk("irq idle", 8'h00, {7'h00, irq});
    ext[7:0] = 8'h05;
    ext[24]  = 1'b0;
    @(posedge core_clk) #1;
    ext[7:0] = 8'h02;
    ext[24]  = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk("irq", 8'h01, {7'h00, irq});
    rdc(5'h0e, 8'h03);
    repeat (5) @(posedge core_clk);
    #1 chk("irq held", 8'h01, {7'h00, irq});
    host_u.wr(B + 10'h011, 8'h03);
    @(posedge core_clk) #1;
    chk("irq clear", 8'h00, {7'h00, irq});
    rdc(5'h11, 8'h00);
    rdc(5'h0e, 8'h00);
    $display("test events done");
    host_u.rd(10'h320, d, v);
    chk("out of window", 8'h00, {7'h00, v});
    host_u.rd(10'h340, d, v);
    chk("other base", 8'h00, {7'h00, v});
    $display("test decode done");
    close_out();
  end
endmodule
